// ### common/crs_consts.svh
// Constants of the CMOS reference clock output selector
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

// ****************************************
// Mode field code and divider count step
// ****************************************
`define CRS_MODE_OFF   2'h0
`define CRS_CNT_STEP   2'h1

// ****************************************
// Reset values
// ****************************************
// Pin image: powerdown taken as asserted until the first samples arrive
`define CRS_PINS_RST   6'h01
// State: power-down set, all outputs low and undriven
`define CRS_STATE_RST  12'h010

`endif

// ### common/crs_pkg.sv
// Types of the CMOS reference clock output selector
`default_nettype none

package crs_pkg;

    typedef enum logic [1:0] {
        CRS_FUNC_AUX  = 2'b00,
        CRS_FUNC_REF  = 2'b01,
        CRS_FUNC_DIV2 = 2'b10,
        CRS_FUNC_DIV4 = 2'b11
    } crs_func_t;

    // Asynchronous pin inputs, powerdown in bit 0
    typedef struct packed {
        logic       diff_ref;
        logic       se_ref;
        logic       ref_sel;
        logic [1:0] strap;
        logic       powerdown;
    } crs_pins_t;

    typedef struct packed {
        crs_pins_t s1;
        crs_pins_t s2;
    } crs_sync_t;

    typedef struct packed {
        logic       ref_lvl;
        logic [1:0] cnt;
        crs_func_t  func_c;
        crs_func_t  func_d;
        logic       pd;
        logic       out_c;
        logic       oe_c;
        logic       out_d;
        logic       oe_d;
    } crs_state_t;

endpackage : crs_pkg

`default_nettype wire

// ### core/crs_pin_sync.sv
// Two-stage synchroniser for the pin inputs
`include "crs_consts.svh"
`default_nettype none

module crs_pin_sync (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire crs_pkg::crs_pins_t pins_in,
    output var  crs_pkg::crs_pins_t pins_out
);
    import crs_pkg::*;

    crs_sync_t st_q;
    crs_sync_t st_d;

    // First stage is read only by the second stage
    always_comb begin
        st_d    = st_q;
        st_d.s1 = pins_in;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= {crs_pins_t'(`CRS_PINS_RST), crs_pins_t'(`CRS_PINS_RST)};
        end else begin
            st_q <= st_d;
        end
    end

    assign pins_out = st_q.s2;

endmodule : crs_pin_sync

`default_nettype wire

// ### core/crs_refclk_out.sv
// CMOS reference clock and over-range output selector
`include "crs_consts.svh"
`default_nettype none

// Function
// R1 - Both CMOS output pins can carry the reference clock when configured as clocks.
// R2 - With the straps enabling clocks and power-down low, clocks appear from power-up without any setup.
// R3 - Power-down high disables both outputs, so systems needing the clocks keep it low.
// R4 - With the override set the straps are ignored and each output uses its own mode field.
// R5 - Without override, strap 00 gives over-range or off on both, and any other code gives the plain reference on D.
// R6 - Clock functions win over over-range, which is driven only when enabled on quad parts, else the pin is off.
// R7 - The D clock functions exist only while the C mode field is above zero.
// R8 - Without override, strap 01, 10, 11 give reference, reference/2 and reference/4 on C.
// R9 - With override the C field codes 0..3 give over-range/off, reference, /2 and /4.
// R10 - With override the D field codes 0..3 give over-range/off, reference, /2 and /4.
// R11 - The reference is the differential input when the select pin is low, the single-ended one when high.
// R12 - Dividers count reference edges and selection changes never cut a pulse short.
module crs_refclk_out (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       diff_clk_in,
    input  wire logic       single_ended_clk_in,
    input  wire logic       ref_input_select,
    input  wire logic [1:0] clk_out_strap,
    input  wire logic       powerdown_pin,
    input  wire logic       strap_override_en,
    input  wire logic [1:0] out_c_clk_sel,
    input  wire logic [1:0] out_d_clk_sel,
    input  wire logic       overrange_out_en,
    input  wire logic       quad_channel,
    input  wire logic       overrange_c,
    input  wire logic       overrange_d,
    output logic            aux_out_c,
    output logic            aux_out_c_oe,
    output logic            aux_out_d,
    output logic            aux_out_d_oe
);
    import crs_pkg::*;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    crs_pins_t  pins_raw;
    crs_pins_t  pins_s;
    crs_state_t st_q;
    crs_state_t st_d;
    crs_func_t  want_c;
    crs_func_t  want_d;
    logic       ref_mux;
    logic       aux_oe;
    logic       ovr_c_lvl;
    logic       ovr_d_lvl;

    assign pins_raw = '{diff_ref:  diff_clk_in,
                        se_ref:    single_ended_clk_in,
                        ref_sel:   ref_input_select,
                        strap:     clk_out_strap,
                        powerdown: powerdown_pin};

    crs_pin_sync u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .pins_in  (pins_raw),
        .pins_out (pins_s)
    );

    // ****************************************
    // Function selection
    // ****************************************
    function automatic logic clk_level(crs_func_t f, logic r, logic [1:0] c);
        logic lvl;
        lvl = 1'b0;
        unique case (f)
            CRS_FUNC_AUX:  lvl = 1'b0;
            CRS_FUNC_REF:  lvl = r;
            CRS_FUNC_DIV2: lvl = c[0];
            CRS_FUNC_DIV4: lvl = c[1];
        endcase
        return lvl;
    endfunction : clk_level

    // Reference seen as a sampled level: it must stay well below half the clock rate
    assign ref_mux = pins_s.ref_sel ? pins_s.se_ref : pins_s.diff_ref; // R11

    // Straps are live, so clocks run from power-up with no setup
    assign want_c = strap_override_en ? crs_func_t'(out_c_clk_sel)
                                      : crs_func_t'(pins_s.strap); // R2 R4 R8 R9

    always_comb begin
        want_d = CRS_FUNC_AUX;
        if (strap_override_en) begin
            if (out_c_clk_sel != `CRS_MODE_OFF) begin // R7
                want_d = crs_func_t'(out_d_clk_sel); // R4 R10
            end
        end else if (pins_s.strap != `CRS_MODE_OFF) begin
            want_d = CRS_FUNC_REF; // R5
        end
    end

    // Over-range only on quad parts and only when enabled
    assign aux_oe    = overrange_out_en & quad_channel; // R6
    assign ovr_c_lvl = aux_oe & overrange_c;
    assign ovr_d_lvl = aux_oe & overrange_d;

    // ****************************************
    // State update
    // ****************************************
    always_comb begin
        st_d         = st_q;
        st_d.ref_lvl = ref_mux;
        st_d.pd      = pins_s.powerdown;
        if (ref_mux && !st_q.ref_lvl) begin
            st_d.cnt = st_q.cnt + `CRS_CNT_STEP; // R12
        end
        // A clock is left only while low and a new clock starts only while low: no runt pulses
        // Over-range is left at once, so a flag stuck high cannot hold off a clock
        if (want_c != st_q.func_c && (st_q.func_c == CRS_FUNC_AUX || !st_q.out_c) &&
            (want_c == CRS_FUNC_AUX || !clk_level(want_c, st_d.ref_lvl, st_d.cnt))) begin
            st_d.func_c = want_c; // R12
        end
        if (want_d != st_q.func_d && (st_q.func_d == CRS_FUNC_AUX || !st_q.out_d) &&
            (want_d == CRS_FUNC_AUX || !clk_level(want_d, st_d.ref_lvl, st_d.cnt))) begin
            st_d.func_d = want_d; // R12
        end
        if (st_d.pd) begin
            st_d.out_c = 1'b0; // R3
            st_d.oe_c  = 1'b0;
            st_d.out_d = 1'b0;
            st_d.oe_d  = 1'b0;
        end else begin
            // Clock functions take priority over over-range
            if (st_d.func_c == CRS_FUNC_AUX) begin
                st_d.oe_c  = aux_oe; // R6
                st_d.out_c = ovr_c_lvl;
            end else begin
                st_d.oe_c  = 1'b1; // R1
                st_d.out_c = clk_level(st_d.func_c, st_d.ref_lvl, st_d.cnt);
            end
            if (st_d.func_d == CRS_FUNC_AUX) begin
                st_d.oe_d  = aux_oe; // R6
                st_d.out_d = ovr_d_lvl;
            end else begin
                st_d.oe_d  = 1'b1; // R1
                st_d.out_d = clk_level(st_d.func_d, st_d.ref_lvl, st_d.cnt);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_q <= crs_state_t'(`CRS_STATE_RST);
        end else begin
            st_q <= st_d;
        end
    end

    assign aux_out_c    = st_q.out_c;
    assign aux_out_c_oe = st_q.oe_c;
    assign aux_out_d    = st_q.out_d;
    assign aux_out_d_oe = st_q.oe_d;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_strap_c_map: assert property (!strap_override_en |-> want_c == crs_func_t'(pins_s.strap)) // R8
        else $error("C strap decode wrong");
    a_ovr_c_map: assert property (strap_override_en |-> want_c == crs_func_t'(out_c_clk_sel)) // R9
        else $error("C override decode wrong");
    a_ovr_d_gate: assert property (strap_override_en && out_c_clk_sel == `CRS_MODE_OFF
                                   |-> want_d == CRS_FUNC_AUX) // R7
        else $error("D clock allowed with C off");
    a_ovr_d_map: assert property (strap_override_en && out_c_clk_sel != `CRS_MODE_OFF
                                  |-> want_d == crs_func_t'(out_d_clk_sel)) // R10
        else $error("D override decode wrong");
    a_strap_d_ref: assert property (!strap_override_en |->
                                    want_d == (pins_s.strap != `CRS_MODE_OFF ? CRS_FUNC_REF : CRS_FUNC_AUX)) // R5
        else $error("D strap decode wrong");
    a_pd_off_c: assert property (pins_s.powerdown |=> !aux_out_c && !aux_out_c_oe) // R3
        else $error("C active in power-down");
    a_pd_off_d: assert property (pins_s.powerdown |=> !aux_out_d && !aux_out_d_oe) // R3
        else $error("D active in power-down");
    a_ref_mux: assert property (1'b1 |=> st_q.ref_lvl == $past(ref_mux)) // R11
        else $error("Reference source wrong");
    a_ref_follow: assert property (!st_q.pd && st_q.func_c == CRS_FUNC_REF
                                   |-> aux_out_c_oe && aux_out_c == st_q.ref_lvl) // R1
        else $error("C not copying reference");
    a_div_count: assert property ($rose(st_q.ref_lvl) |-> st_q.cnt == $past(st_q.cnt) + `CRS_CNT_STEP) // R12
        else $error("Divider missed an edge");
    a_switch_clean: assert property ($changed(st_q.func_c) && $past(st_q.func_c) != CRS_FUNC_AUX
                                     |-> !$past(aux_out_c)) // R12
        else $error("C switched while high");
    a_switch_clean_d: assert property ($changed(st_q.func_d) && $past(st_q.func_d) != CRS_FUNC_AUX
                                       |-> !$past(aux_out_d)) // R12
        else $error("D switched while high");
    a_aux_prio: assert property (!st_q.pd && st_q.func_d == CRS_FUNC_AUX
                                 |-> aux_out_d == $past(ovr_d_lvl) && aux_out_d_oe == $past(aux_oe)) // R6
        else $error("D over-range output wrong");
    a_aux_prio_c: assert property (!st_q.pd && st_q.func_c == CRS_FUNC_AUX
                                   |-> aux_out_c == $past(ovr_c_lvl) && aux_out_c_oe == $past(aux_oe)) // R6
        else $error("C over-range output wrong");
    a_ref_follow_d: assert property (!st_q.pd && st_q.func_d == CRS_FUNC_REF
                                     |-> aux_out_d_oe && aux_out_d == st_q.ref_lvl) // R1
        else $error("D not copying reference");
    a_div2_c: assert property (!st_q.pd && st_q.func_c == CRS_FUNC_DIV2 |-> aux_out_c == st_q.cnt[0]) // R8
        else $error("C half rate wrong");
    a_div4_c: assert property (!st_q.pd && st_q.func_c == CRS_FUNC_DIV4 |-> aux_out_c == st_q.cnt[1]) // R9
        else $error("C quarter rate wrong");
    a_div2_d: assert property (!st_q.pd && st_q.func_d == CRS_FUNC_DIV2 |-> aux_out_d == st_q.cnt[0]) // R10
        else $error("D half rate wrong");
    a_div4_d: assert property (!st_q.pd && st_q.func_d == CRS_FUNC_DIV4 |-> aux_out_d == st_q.cnt[1]) // R10
        else $error("D quarter rate wrong");

    c_div4_c: cover property (st_q.func_c == CRS_FUNC_DIV4 && !st_q.pd ##1 $rose(aux_out_c));
    c_div2_d: cover property (st_q.func_d == CRS_FUNC_DIV2 && !st_q.pd ##1 $rose(aux_out_d));
    c_pd_cut: cover property (aux_out_c_oe ##1 $rose(st_q.pd));
    c_ovr_hi: cover property (st_q.func_c == CRS_FUNC_AUX && aux_out_c);
    c_leave_ovr: cover property (st_q.func_c == CRS_FUNC_AUX && aux_out_c ##1 st_q.func_c == CRS_FUNC_REF);

endmodule : crs_refclk_out

`default_nettype wire

// ### verif/crs_far_model.sv
// Far-side model: reference sources and a logic block sampling the outputs on the falling clock edge
`default_nettype none

module crs_far_model (
    input  wire logic        clock,
    input  wire logic        clr,
    input  wire logic        aux_c,
    input  wire logic        aux_d,
    output logic             diff_ref,
    output logic             se_ref,
    output logic [15:0]      edges_c,
    output logic [15:0]      edges_d,
    output logic [7:0]       min_high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph = 4'h0;
    logic [1:0] prev = 2'h0;
    logic [7:0] run = 8'h0;

    // Two rates, single-ended at half the differential, so the input select shows in the edge count
    assign diff_ref = ph[2];
    assign se_ref   = ph[3];
    always @(negedge clock) begin
        ph <= ph + 4'h1;
    end

    // ****************************************
    // Consumer: edge counts on C and D, shortest high pulse on C only
    // ****************************************
    // Sampled on the falling edge, away from the output flops
    always @(negedge clock) begin
        prev <= {aux_c, aux_d};
        // Run counts through the clear so a pulse that straddles it is not seen as short
        run  <= aux_c ? ((run == 8'hff) ? run : run + 8'h1) : 8'h0;
        if (clr) begin
            edges_c  <= 16'h0;
            edges_d  <= 16'h0;
            min_high <= 8'hff;
        end else begin
            if (aux_c && !prev[1]) edges_c <= edges_c + 16'h1;
            if (aux_d && !prev[0]) edges_d <= edges_d + 16'h1;
            if (!aux_c && prev[1] && run < min_high) min_high <= run;
        end
    end
endmodule : crs_far_model

`default_nettype wire

// ### verif/test_crs_refclk_out.sv
// Self-checking testbench of the CMOS reference clock output selector
`default_nettype none

module test_crs_refclk_out;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        diff_ref, se_ref, ref_sel = 1'b0, pd = 1'b1, ovr = 1'b0;
    logic [1:0]  strap = 2'h0, csel = 2'h0, dsel = 2'h0;
    logic        or_en = 1'b0, quad = 1'b0, or_c = 1'b0, or_d = 1'b0, clr = 1'b1;
    logic        out_c, oe_c, out_d, oe_d;
    logic [15:0] edges_c, edges_d;
    logic [7:0]  min_high;
    int          errors = 0;
    int          samples_checked = 0;

    always #4 clock = ~clock;

    crs_refclk_out i_dut (.clock(clock), .reset_n(reset_n), .diff_clk_in(diff_ref),
        .single_ended_clk_in(se_ref), .ref_input_select(ref_sel), .clk_out_strap(strap),
        .powerdown_pin(pd), .strap_override_en(ovr), .out_c_clk_sel(csel), .out_d_clk_sel(dsel),
        .overrange_out_en(or_en), .quad_channel(quad), .overrange_c(or_c), .overrange_d(or_d),
        .aux_out_c(out_c), .aux_out_c_oe(oe_c), .aux_out_d(out_d), .aux_out_d_oe(oe_d));

    crs_far_model i_far (.clock(clock), .clr(clr), .aux_c(out_c), .aux_d(out_d), .diff_ref(diff_ref),
        .se_ref(se_ref), .edges_c(edges_c), .edges_d(edges_d), .min_high(min_high));

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Window of 256 cycles is a whole number of every output period
    task automatic measure(input int ec, input int ed, input logic eoc, input logic eod);
        repeat (64) @(negedge clock);
        clr <= 1'b1;
        @(negedge clock);
        clr <= 1'b0;
        repeat (256) @(negedge clock);
        #1;
        check("edges_c", edges_c, 16'(ec));
        check("edges_d", edges_d, 16'(ed));
        check("oe_c", {15'h0, oe_c}, {15'h0, eoc});
        check("oe_d", {15'h0, oe_d}, {15'h0, eod});
        if (ec != 0) check("min_high_ok", {15'h0, min_high >= 8'h04}, 16'h1);
        @(negedge clock);
    endtask : measure

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        pd = 1'b0;
        strap = 2'h1;
        repeat (2) @(posedge clock);
        #1 check("oe_c_early", {15'h0, oe_c}, 16'h0);
        @(posedge clock);
        #1 check("oe_c_up", {15'h0, oe_c & oe_d}, 16'h1);
        @(negedge clock);
        {or_en, quad, or_c, or_d} = 4'hf;
        for (int s = 0; s < 4; s++) begin
            strap = 2'(s);
            measure(s == 0 ? 0 : 64 >> s, s == 0 ? 0 : 32, 1'b1, 1'b1);
            if (s == 0) check("or_level", {14'h0, out_c, out_d}, 16'h3);
        end
        {or_en, ovr, strap} = 4'h7;
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 4; d++) begin
                csel = 2'(c);
                dsel = 2'(d);
                measure(c == 0 ? 0 : 64 >> c, (c == 0 || d == 0) ? 0 : 64 >> d, c != 0, c != 0 && d != 0);
            end
        end
        {ovr, strap, ref_sel} = 4'h3;
        measure(16, 16, 1'b1, 1'b1);
        {ref_sel, strap, or_en, quad, or_c, or_d} = 6'h02;
        measure(0, 0, 1'b0, 1'b0);
        {or_en, quad} = 2'h3;
        repeat (3) @(negedge clock);
        check("or_pins", {12'h0, out_c, oe_c, out_d, oe_d}, 16'hd);
        strap = 2'h1;
        pd = 1'b1;
        measure(0, 0, 1'b0, 1'b0);
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        test_done();
    end
endmodule : test_crs_refclk_out

`default_nettype wire
